// ==== core/ocmp_dev.sv ====
/*
 Device end: counter, two compare units, byte access, pin override.
 Assumes core on ocmp_if.dev, one clock, tick as prescaled timer clock.
*/
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "ocmp_regs.svh"

// Notes on behaviour
// R1: units compare full counter continuously
// R2: match sets flag one timer tick later
// R3: enabled flag interrupts; ack or one clears
// R4: unit A may define counter top
// R5: PWM modes buffer compare, load at top/count_lower_limit
// R6: writes hit buffer or active register
// R7: only writes change compare; direct reads
// R8: high byte held, low write commits both
// R9: force strobe acts latch, no flag/counter; ignored in PWM modes
// R10: counter write blocks next tick's matches
// R11: software avoids writing counter to top
// R12: latch keeps value across mode change
// R13: action bits apply immediately, unbuffered
// R14: reset clears output latches
// R15: nonzero action overrides port, direction kept
// R16: action zero leaves latch unchanged
// R17: action bits do not touch capture
// R18: action bits never alter counting
// R19: software toggles capture edge then clears
// R20: software initialises latch before direction
// R21: mode 4 clears on A, 12 on capture
module ocmp_dev (
   input  wire logic  clk,
   input  wire logic  sys_rst,
   input  wire logic  tick,
   input  wire logic  [15:0] capture_value,
   input  wire logic  [1:0]  port_value,
   ocmp_if.dev        bus,
   output logic [1:0] pin_out,
   output logic [1:0] pin_oe
);
   typedef struct packed {
      logic [15:0] cnt;
      logic [7:0]  hold;
      logic [3:0]  wgm;
      logic [3:0]  action;
      logic [1:0]  irqen;
      logic [1:0]  dir;
      logic        block;
      logic [7:0]  rdata;
      logic        irq;
      logic [1:0]  pout;
      logic [1:0]  poe;
   } dev_t;

   dev_t s_r, s_nxt;
   logic [15:0] cmp [2];
   logic [15:0] bufv [2];
   logic [1:0]  mt, flg, lat, wv, fs, fc;
   logic        pwm, top, count_lower_limit_hit, cnt_wr;
   logic [15:0] top_v;

   function automatic logic is_pwm(input logic [3:0] w);
      is_pwm = !(w == `OC_WGM_NORMAL || w == `OC_WGM_CTC_A || w == `OC_WGM_CTC_CAP);
   endfunction : is_pwm

   always_comb begin
      case (s_r.wgm)                              // see R4 see R21
         `OC_WGM_CTC_A, 4'hf: top_v = cmp[0];
         `OC_WGM_CTC_CAP, 4'he: top_v = capture_value;
         4'h5: top_v = 16'h00ff;
         4'h6: top_v = 16'h01ff;
         4'h7: top_v = 16'h03ff;
         default: top_v = `OC_CNT_MAX;
      endcase
   end

   assign pwm        = is_pwm(s_r.wgm);           // see R5
   assign top        = (s_r.cnt == top_v) && !s_r.block;   // see R11
   assign count_lower_limit_hit = (s_r.cnt == 16'h0000);
   assign cnt_wr     = bus.wr && (bus.addr == `OC_ADDR_CNT_LO);

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gu
         assign wv[g] = bus.wr && (bus.addr == (g ? `OC_ADDR_CMPB_LO : `OC_ADDR_CMPA_LO));
         assign fs[g] = bus.wr && (bus.addr == `OC_ADDR_FORCE) && bus.wdata[g];
         assign fc[g] = bus.irq_ack[g] ||
                        (bus.wr && (bus.addr == `OC_ADDR_FLAGS) && bus.wdata[g]);
         ocmp_unit u (
            .clk                  (clk),
            .sys_rst              (sys_rst),
            .tick                 (tick),
            .counter_value        (s_r.cnt),
            .pwm_mode             (pwm),
            .at_update            (top || count_lower_limit_hit),
            .pwm_count_lower_limit           (count_lower_limit_hit),
            .block                (s_r.block),
            .wr_val               (wv[g]),
            .wr_data              ({s_r.hold, bus.wdata}),   // see R8
            .output_action_select (s_r.action[2*g +: 2]),
            .force_compare_strobe (fs[g]),
            .flag_clr             (fc[g]),
            .compare_value        (cmp[g]),
            .buffer_value         (bufv[g]),
            .match                (mt[g]),
            .compare_match_flag   (flg[g]),
            .compare_output_latch (lat[g])
         );
      end
   endgenerate

   always_comb begin
      s_nxt = s_r;
      s_nxt.rdata = 8'h00;
      if (bus.wr) begin
         case (bus.addr)
            `OC_ADDR_CMPA_HI, `OC_ADDR_CMPB_HI, `OC_ADDR_CNT_HI: s_nxt.hold = bus.wdata;
            `OC_ADDR_CTRL:   s_nxt.wgm    = bus.wdata[3:0];   // see R12
            `OC_ADDR_IRQEN:  s_nxt.irqen  = bus.wdata[1:0];
            `OC_ADDR_ACTION: s_nxt.action = bus.wdata[3:0];   // see R13 see R17
            `OC_ADDR_DIR:    s_nxt.dir    = bus.wdata[1:0];
            default: ;
         endcase
      end
      if (tick) s_nxt.block = 1'b0;
      if (tick) begin                             // see R18
         if ((s_r.wgm == `OC_WGM_CTC_A && mt[0]) || top) s_nxt.cnt = 16'h0000;
         else s_nxt.cnt = s_r.cnt + 16'h0001;
      end
      if (cnt_wr) begin                           // see R10
         s_nxt.cnt   = {s_r.hold, bus.wdata};
         s_nxt.block = 1'b1;
      end
      if (bus.rd) begin
         case (bus.addr)
            `OC_ADDR_CTRL:    s_nxt.rdata = {4'h0, s_r.wgm};
            // pwm modes read the buffer, others the active value
            `OC_ADDR_CMPA_LO: s_nxt.rdata = pwm ? bufv[0][7:0] : cmp[0][7:0];    // see R6 see R7
            `OC_ADDR_CMPA_HI: s_nxt.rdata = pwm ? bufv[0][15:8] : cmp[0][15:8];
            `OC_ADDR_CMPB_LO: s_nxt.rdata = pwm ? bufv[1][7:0] : cmp[1][7:0];
            `OC_ADDR_CMPB_HI: s_nxt.rdata = pwm ? bufv[1][15:8] : cmp[1][15:8];
            `OC_ADDR_CNT_LO:  s_nxt.rdata = s_r.cnt[7:0];
            `OC_ADDR_CNT_HI:  s_nxt.rdata = s_r.cnt[15:8];
            `OC_ADDR_FLAGS:   s_nxt.rdata = {6'h00, flg};
            `OC_ADDR_IRQEN:   s_nxt.rdata = {6'h00, s_r.irqen};
            `OC_ADDR_ACTION:  s_nxt.rdata = {4'h0, s_r.action};
            `OC_ADDR_DIR:     s_nxt.rdata = {6'h00, s_r.dir};
            `OC_ADDR_STATUS:  s_nxt.rdata = {6'h00, lat};
            default:          s_nxt.rdata = 8'h00;
         endcase
      end
      s_nxt.irq = |(flg & s_r.irqen);             // see R3
      for (int i = 0; i < 2; i++) begin           // see R15
         s_nxt.pout[i] = (s_r.action[2*i +: 2] != 2'h0) ? lat[i] : port_value[i];
         s_nxt.poe[i]  = s_r.dir[i];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.rdata = s_r.rdata;
   assign bus.irq   = s_r.irq;
   assign pin_out   = s_r.pout;
   assign pin_oe    = s_r.poe;
endmodule : ocmp_dev

// ==== common/ocmp_regs.svh ====
/*
 Offsets, field positions and mode codes of the compare section.
 Assumes inclusion by bare name from any design or bench file.
*/
`ifndef OCMP_REGS_SVH
`define OCMP_REGS_SVH

// register offsets on the side port (8-bit data)
`define OC_ADDR_CTRL      4'h0
`define OC_ADDR_CMPA_LO   4'h1
`define OC_ADDR_CMPA_HI   4'h2
`define OC_ADDR_CMPB_LO   4'h3
`define OC_ADDR_CMPB_HI   4'h4
`define OC_ADDR_CNT_LO    4'h5
`define OC_ADDR_CNT_HI    4'h6
`define OC_ADDR_FLAGS     4'h7
`define OC_ADDR_IRQEN     4'h8
`define OC_ADDR_ACTION    4'h9
`define OC_ADDR_FORCE     4'ha
`define OC_ADDR_DIR       4'hb
`define OC_ADDR_STATUS    4'hc

// field positions
`define OC_BIT_A          0
`define OC_BIT_B          1
`define OC_WGM_W          4

// waveform mode codes
`define OC_WGM_NORMAL     4'h0
`define OC_WGM_CTC_A      4'h4
`define OC_WGM_CTC_CAP    4'hc
`define OC_CNT_MAX        16'hffff

// reset values
`define OC_RST_CMP        16'h0000
`define OC_RST_LATCH      1'b0

`endif

// ==== common/ocmp_pkg.sv ====
/*
 Types of the compare section; only the host end uses them.
 Assumes ocmp_regs.svh is compiled beside it.
*/
package ocmp_pkg;
   typedef enum logic [1:0] {
      ACT_NONE   = 2'h0,
      ACT_TOGGLE = 2'h1,
      ACT_CLEAR  = 2'h2,
      ACT_SET    = 2'h3
   } action_t;

   typedef enum logic [1:0] {
      H_IDLE = 2'h0,
      H_HIGH = 2'h1,
      H_LOW  = 2'h3
   } host_state_t;
endpackage : ocmp_pkg

// ==== common/ocmp_if.sv ====
/*
 Byte-wide I/O bus between processor core and the compare section.
 Assumes one clock shared by both ends; no clocking block.
*/
`timescale 1ns/10ps
interface ocmp_if;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       irq;
   logic [1:0] irq_ack;

   modport dev  (input addr, input wdata, input wr, input rd, input irq_ack,
                 output rdata, output irq);
   modport core (output addr, output wdata, output wr, output rd, output irq_ack,
                 input rdata, input irq);
endinterface : ocmp_if

// ==== core/ocmp_unit.sv ====
/*
 One compare unit: buffered compare value, match, flag and output latch.
 Assumes the parent supplies decoded strobes and the running counter.
*/
`timescale 1ns/10ps
module ocmp_unit (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        tick,
   input  wire logic [15:0] counter_value,
   input  wire logic        pwm_mode,
   input  wire logic        at_update,
   input  wire logic        pwm_count_lower_limit,
   input  wire logic        block,
   input  wire logic        wr_val,
   input  wire logic [15:0] wr_data,
   input  wire logic [1:0]  output_action_select,
   input  wire logic        force_compare_strobe,
   input  wire logic        flag_clr,
   output logic [15:0]      compare_value,
   output logic [15:0]      buffer_value,
   output logic             match,
   output logic             compare_match_flag,
   output logic             compare_output_latch
);
   typedef struct packed {
      logic [15:0] buf_v;
      logic [15:0] act_v;
      logic        pend;
      logic        flag;
      logic        latch;
   } unit_t;

   unit_t s_r, s_nxt;

   function automatic logic act(input logic [1:0] a, input logic cur);
      case (a)
         2'h1:    act = ~cur;
         2'h2:    act = 1'b0;
         2'h3:    act = 1'b1;
         default: act = cur;                     // see R16
      endcase
   endfunction : act

   always_comb begin
      s_nxt = s_r;
      match = (counter_value == s_r.act_v) && !block;   // see R1 see R10
      if (wr_val) begin                          // see R6 see R7
         if (pwm_mode) s_nxt.buf_v = wr_data;
         else begin
            s_nxt.buf_v = wr_data;
            s_nxt.act_v = wr_data;
         end
      end
      if (tick && pwm_mode && at_update) s_nxt.act_v = s_r.buf_v;   // see R5
      if (flag_clr) s_nxt.flag = 1'b0;           // see R3
      if (tick) begin
         s_nxt.pend = match;
         if (s_r.pend) s_nxt.flag = 1'b1;        // see R2
         if (match) begin
            if (pwm_mode)                        // see R18
               s_nxt.latch = (output_action_select == 2'h2) ? 1'b0 :
                             (output_action_select == 2'h3) ? 1'b1 : s_r.latch;
            else
               s_nxt.latch = act(output_action_select, s_r.latch);   // see R13
         end else if (pwm_mode && pwm_count_lower_limit) begin
            s_nxt.latch = (output_action_select == 2'h2) ? 1'b1 :
                          (output_action_select == 2'h3) ? 1'b0 : s_r.latch;
         end
      end
      if (force_compare_strobe && !pwm_mode)     // see R9
         s_nxt.latch = act(output_action_select, s_r.latch);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_r <= '0;                              // see R14
      end else begin
         s_r <= s_nxt;                           // see R12
      end
   end

   assign compare_value        = s_r.act_v;
   assign buffer_value         = s_r.buf_v;
   assign compare_match_flag   = s_r.flag;
   assign compare_output_latch = s_r.latch;
endmodule : ocmp_unit

// ==== core/ocmp_host.sv ====
/*
 Core end: turns user commands into byte accesses, high byte first.
 Assumes device on ocmp_if.core; one command at a time.
*/
`timescale 1ns/10ps
`include "ocmp_regs.svh"
module ocmp_host (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        cmd_wr16,
   input  wire logic        cmd_wr8,
   input  wire logic        cmd_rd8,
   input  wire logic        cmd_ack_irq,
   input  wire logic [3:0]  cmd_addr,
   input  wire logic [15:0] cmd_data,
   output logic             busy,
   output logic [7:0]       rd_data,
   output logic             rd_valid,
   output logic             irq_seen,
   ocmp_if.core             bus
);
   typedef struct packed {
      ocmp_pkg::host_state_t st;
      logic [3:0]  addr;
      logic [7:0]  lo;
      logic [3:0]  baddr;
      logic [7:0]  bdata;
      logic        wr;
      logic        rd;
      logic        rdp;
      logic [7:0]  rdat;
      logic        rv;
      logic [1:0]  ack;
      logic        irqs;
   } host_t;
   host_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.wr  = 1'b0;
      s_nxt.rd  = 1'b0;
      s_nxt.rv  = s_r.rdp;
      // rdata stands one cycle after rd, so capture a cycle later
      s_nxt.rdp = s_r.rd;
      s_nxt.ack = 2'h0;
      s_nxt.irqs = bus.irq;
      if (s_r.rdp) s_nxt.rdat = bus.rdata;
      case (s_r.st)
         ocmp_pkg::H_IDLE: begin
            if (cmd_wr16) begin                   // see R8
               s_nxt.wr    = 1'b1;
               s_nxt.baddr = cmd_addr + 4'h1;
               s_nxt.bdata = cmd_data[15:8];
               s_nxt.addr  = cmd_addr;
               s_nxt.lo    = cmd_data[7:0];
               s_nxt.st    = ocmp_pkg::H_HIGH;
            end else if (cmd_wr8) begin
               s_nxt.wr    = 1'b1;
               s_nxt.baddr = cmd_addr;
               s_nxt.bdata = cmd_data[7:0];
            end else if (cmd_rd8) begin
               s_nxt.rd    = 1'b1;
               s_nxt.baddr = cmd_addr;
            end else if (cmd_ack_irq) begin       // see R3
               s_nxt.ack = cmd_data[1:0];
            end
         end
         ocmp_pkg::H_HIGH: begin
            s_nxt.wr    = 1'b1;
            s_nxt.baddr = s_r.addr;
            s_nxt.bdata = s_r.lo;
            s_nxt.st    = ocmp_pkg::H_LOW;
         end
         ocmp_pkg::H_LOW: s_nxt.st = ocmp_pkg::H_IDLE;
         default:         s_nxt.st = ocmp_pkg::H_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.addr    = s_r.baddr;
   assign bus.wdata   = s_r.bdata;
   assign bus.wr      = s_r.wr;
   assign bus.rd      = s_r.rd;
   assign bus.irq_ack = s_r.ack;
   assign busy        = (s_r.st != ocmp_pkg::H_IDLE);
   assign rd_data     = s_r.rdat;
   assign rd_valid    = s_r.rv;
   assign irq_seen    = s_r.irqs;
endmodule : ocmp_host

// ==== verification/ocmp_bus_assertions.sv ====
/*
 Concurrent checks on the byte bus that joins the host and device ends.
 Assumes one clock, an async active-high reset, instantiated beside the bus.
*/
`timescale 1ns/10ps
`include "ocmp_regs.svh"
module ocmp_bus_assertions (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       irq,
   input wire logic [1:0] irq_ack
);
   logic [1:0] en_r;

   // shadow of the enable bits, rebuilt from bus writes alone
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         en_r <= 2'h0;
      end else if (wr && addr == `OC_ADDR_IRQEN) begin
         en_r <= wdata[1:0];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_strobe_excl: assert property (!(wr && rd))
      else $error("read and write strobes together");
   chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("read data outside its cycle");
   chk_unmapped_zero: assert property (rd && addr == 4'hf |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_cmpa_pair: assert property (wr && addr == `OC_ADDR_CMPA_HI |=> wr && addr == `OC_ADDR_CMPA_LO)
      else $error("compare a high byte not followed by low");
   chk_cmpb_low: assert property (wr && addr == `OC_ADDR_CMPB_LO |-> $past(wr) && $past(addr) == `OC_ADDR_CMPB_HI)
      else $error("compare b low byte without high first");
   chk_cnt_pair: assert property (wr && addr == `OC_ADDR_CNT_HI |=> wr && addr == `OC_ADDR_CNT_LO)
      else $error("counter high byte not followed by low");
   chk_ack_pulse: assert property (irq_ack != 2'h0 |=> irq_ack == 2'h0)
      else $error("acknowledge longer than one cycle");
   chk_irq_needs_en: assert property (en_r == 2'h0 && $past(en_r) == 2'h0 |-> !irq)
      else $error("interrupt with no unit enabled");
   chk_irq_drop: assert property (wr && addr == `OC_ADDR_IRQEN && wdata == 8'h00 ##1 !(wr && addr == `OC_ADDR_IRQEN) |=> !irq)
      else $error("interrupt stays after disable");
endmodule : ocmp_bus_assertions

// ==== verification/testbench.sv ====
/*
 Self-checking bench: host and device ends joined over the byte bus.
 Assumes the package, bus interface, both design ends and checker compiled first.
*/
`timescale 1ns/10ps
`include "ocmp_regs.svh"
module testbench;
   logic        clk;
   logic        sys_rst;
   logic        tick;
   logic [15:0] capture_value;
   logic [1:0]  port_value;
   logic        cmd_wr16;
   logic        cmd_wr8;
   logic        cmd_rd8;
   logic        cmd_ack_irq;
   logic [3:0]  cmd_addr;
   logic [15:0] cmd_data;
   logic        busy;
   logic [7:0]  rd_data;
   logic        rd_valid;
   logic        irq_seen;
   logic [1:0]  pin_out;
   logic [1:0]  pin_oe;
   logic [7:0]  exp_q[$];
   int          fail_count;
   int          n_tests;
   int          cycles;
   logic [15:0] v;
   logic [7:0]  act_tab[4] = '{8'h07, 8'h0d, 8'h03, 8'h08};
   logic [7:0]  lat_tab[4] = '{8'h03, 8'h02, 8'h03, 8'h01};
   logic [7:0]  mode_tab[3] = '{8'h04, 8'h0c, 8'h0f};
   logic [7:0]  cnt_tab[3] = '{8'h02, 8'h04, 8'h02};

   ocmp_if bus ();
   ocmp_host ocmp_host_i (.clk(clk), .sys_rst(sys_rst), .cmd_wr16(cmd_wr16), .cmd_wr8(cmd_wr8),
      .cmd_rd8(cmd_rd8), .cmd_ack_irq(cmd_ack_irq), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid), .irq_seen(irq_seen), .bus(bus));
   ocmp_dev ocmp_dev_i (.clk(clk), .sys_rst(sys_rst), .tick(tick), .capture_value(capture_value),
      .port_value(port_value), .bus(bus), .pin_out(pin_out), .pin_oe(pin_oe));
   ocmp_bus_assertions ocmp_bus_assertions_i (.clk(clk), .sys_rst(sys_rst), .addr(bus.addr),
      .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .irq(bus.irq),
      .irq_ack(bus.irq_ack));

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // kind is one-hot: wr16, wr8, rd8, ack; host refuses orders while busy
   task automatic cmd(input logic [3:0] kind, input logic [3:0] a, input logic [15:0] d);
      int k;
      @(posedge clk);
      {cmd_ack_irq, cmd_rd8, cmd_wr8, cmd_wr16} <= kind;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge clk);
      {cmd_ack_irq, cmd_rd8, cmd_wr8, cmd_wr16} <= 4'h0;
      k = 0;
      repeat (4) @(posedge clk);
      #1;
      while (busy !== 1'b0 && k < 20) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask : cmd

   task automatic rd8(input logic [3:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      cmd(4'h4, a, 16'h0000);
   endtask : rd8

   task automatic rd16(input logic [3:0] a, input logic [15:0] exp);
      rd8(a, exp[7:0]);
      rd8(a + 4'h1, exp[15:8]);
   endtask : rd16

   // timer clock stands still except inside this task
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
      end
   endtask : ticks

   task automatic close_out();
      $display("mismatches %0d comparisons %0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("spare read", 8'h00, 8'hff);
         end else begin
            check("read data", exp_q.pop_front(), rd_data);
         end
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      {sys_rst, tick, cmd_wr16, cmd_wr8, cmd_rd8, cmd_ack_irq} = 6'h20;
      {capture_value, port_value, cmd_addr, cmd_data} = {16'h0004, 2'h0, 4'h0, 16'h0000};
      {fail_count, n_tests, cycles} = 0;
      void'($urandom(35929));
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd16(`OC_ADDR_CMPA_LO, 16'h0000);
      rd8(`OC_ADDR_STATUS, 8'h00);
      rd8(4'hf, 8'h00);
      for (int i = 0; i < 2; i++) begin
         v = 16'($urandom);
         cmd(4'h1, i ? `OC_ADDR_CMPB_LO : `OC_ADDR_CMPA_LO, v);
         rd16(i ? `OC_ADDR_CMPB_LO : `OC_ADDR_CMPA_LO, v);
      end
      cmd(4'h1, `OC_ADDR_CMPA_LO, 16'h0010);
      cmd(4'h1, `OC_ADDR_CMPB_LO, 16'h0011);
      cmd(4'h1, `OC_ADDR_CNT_LO, 16'h0010);
      ticks(3);
      rd8(`OC_ADDR_FLAGS, 8'h02);
      cmd(4'h2, `OC_ADDR_FLAGS, 16'h0003);
      cmd(4'h1, `OC_ADDR_CNT_LO, 16'h000e);
      ticks(3);
      rd8(`OC_ADDR_FLAGS, 8'h00);
      ticks(1);
      rd8(`OC_ADDR_FLAGS, 8'h01);
      ticks(1);
      rd8(`OC_ADDR_FLAGS, 8'h03);
      cmd(4'h2, `OC_ADDR_FLAGS, 16'h0002);
      rd8(`OC_ADDR_FLAGS, 8'h01);
      cmd(4'h2, `OC_ADDR_IRQEN, 16'h0001);
      check("irq seen", 8'h01, {7'h00, irq_seen});
      cmd(4'h8, 4'h0, 16'h0001);
      rd8(`OC_ADDR_FLAGS, 8'h00);
      check("irq seen", 8'h00, {7'h00, irq_seen});
      cmd(4'h2, `OC_ADDR_IRQEN, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         cmd(4'h2, `OC_ADDR_ACTION, {8'h00, act_tab[i]});
         cmd(4'h2, `OC_ADDR_FORCE, 16'h0003);
         rd8(`OC_ADDR_STATUS, lat_tab[i]);
      end
      rd8(`OC_ADDR_FLAGS, 8'h00);
      port_value <= 2'($urandom) | 2'h2;
      cmd(4'h2, `OC_ADDR_DIR, 16'h0003);
      check("pin enable", 8'h03, {6'h00, pin_oe});
      check("pin value", {7'h00, port_value[0]}, {6'h00, pin_out});
      cmd(4'h2, `OC_ADDR_DIR, 16'h0000);
      check("pin enable", 8'h00, {6'h00, pin_oe});
      cmd(4'h2, `OC_ADDR_CTRL, 16'h0005);
      rd8(`OC_ADDR_STATUS, 8'h01);
      cmd(4'h2, `OC_ADDR_ACTION, 16'h0001);
      cmd(4'h2, `OC_ADDR_FORCE, 16'h0003);
      rd8(`OC_ADDR_STATUS, 8'h01);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd8(`OC_ADDR_STATUS, 8'h00);
      cmd(4'h2, `OC_ADDR_CTRL, 16'h0005);
      cmd(4'h1, `OC_ADDR_CMPB_LO, 16'h0032);
      rd16(`OC_ADDR_CMPB_LO, 16'h0032);
      cmd(4'h1, `OC_ADDR_CNT_LO, 16'h0030);
      ticks(5);
      rd8(`OC_ADDR_FLAGS, 8'h00);
      cmd(4'h1, `OC_ADDR_CNT_LO, 16'h00fe);
      ticks(60);
      rd8(`OC_ADDR_FLAGS, 8'h03);
      for (int i = 0; i < 3; i++) begin
         cmd(4'h2, `OC_ADDR_CTRL, {8'h00, mode_tab[i]});
         cmd(4'h1, `OC_ADDR_CMPA_LO, 16'h0005);
         cmd(4'h1, `OC_ADDR_CNT_LO, 16'h0000);
         ticks(14);
         rd8(`OC_ADDR_CNT_LO, cnt_tab[i]);
      end
      repeat (4) @(posedge clk);
      close_out();
   end
endmodule : testbench
